// File: rtl/ftsp_pkg.sv
// Shared constants and types for the flow-through SRAM port
`default_nettype none
package ftsp_pkg;
   localparam int ADDR_W = 19;            // 512K words
   localparam int LANES = 4;              // Byte lanes, wide organisation
   localparam int LANE_W = 9;             // Eight data bits plus parity
   localparam int DATA_W = LANES * LANE_W;
   localparam int BURST_W = 2;            // Burst counter width
   localparam int MEM_DEPTH = 1 << ADDR_W;
   localparam logic [DATA_W-1:0] DQ_RST = 36'h0_0000_0000;
   localparam logic [LANES-1:0] BW_RST = 4'hf;
   localparam logic [BURST_W-1:0] CNT_ONE = 2'h1;
   localparam logic [BURST_W-1:0] CNT_ZERO = 2'h0;
   // Operation held by the port for the current cycle
   typedef enum logic [1:0] {OP_IDLE, OP_READ, OP_WRITE} ftsp_op_t;
endpackage
`default_nettype wire

// File: rtl/ftsp_rdbuf_if.sv
// Valid/ready carrier between the port core and its read-data buffer
`default_nettype none
interface ftsp_rdbuf_if;
   import ftsp_pkg::*;
   logic in_valid;
   logic in_ready;
   logic [DATA_W-1:0] in_data;
   logic out_valid;
   logic out_ready;
   logic [DATA_W-1:0] out_data;
   modport src_mp (output in_valid, in_data, out_ready,
                   input in_ready, out_valid, out_data);
   modport buf_mp (input in_valid, in_data, out_ready,
                   output in_ready, out_valid, out_data);
endinterface
`default_nettype wire

// File: rtl/ftsp_rdbuf.sv
// Two-entry skid buffer for read words
`default_nettype none
module ftsp_rdbuf import ftsp_pkg::*; (
   input wire logic mclk_i,      // System clock
   input wire logic resetn_i,    // Async reset, active low
   ftsp_rdbuf_if.buf_mp bus      // Fill and drain sides
);
   logic out_v_q, out_v_d, sk_v_q, sk_v_d, rdy_q, rdy_d;
   logic [DATA_W-1:0] out_q, out_d, sk_q, sk_d;
   logic push, pop;

   // Skid entry takes the word only while the head is stalled
   always_comb begin
      push = bus.in_valid & rdy_q;
      pop = out_v_q & bus.out_ready;
      out_v_d = out_v_q;
      out_d = out_q;
      sk_v_d = sk_v_q;
      sk_d = sk_q;
      if (!out_v_q || pop) begin
         if (sk_v_q) begin
            out_v_d = 1'b1;
            out_d = sk_q;
            sk_v_d = 1'b0;
         end else begin
            out_v_d = push;
            out_d = push ? bus.in_data : out_q;
         end
      end else if (push) begin
         sk_v_d = 1'b1;
         sk_d = bus.in_data;
      end
      rdy_d = ~sk_v_d;      // Registered so the core sees a clean stall
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         out_v_q <= 1'b0;
         sk_v_q <= 1'b0;
         rdy_q <= 1'b1;
         out_q <= DQ_RST;
         sk_q <= DQ_RST;
      end else begin
         out_v_q <= out_v_d;
         sk_v_q <= sk_v_d;
         rdy_q <= rdy_d;
         out_q <= out_d;
         sk_q <= sk_d;
      end
   end

   assign bus.in_ready = rdy_q;
   assign bus.out_valid = out_v_q;
   assign bus.out_data = out_q;

   // A stalled head word never changes or vanishes
   hold_word_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      out_v_q && !bus.out_ready |=> out_v_q && $stable(out_q))
      else $error("stalled read word lost");
endmodule
`default_nettype wire

// File: rtl/ftsp_port.sv
// Flow-through synchronous burst SRAM port, 512K x 36
// Functional notes
// - All synchronous inputs are captured on the rising clock edge.
// - Inactive clock qualify freezes state, except that sleep still drops drivers and powers down; host may stall with it.
// - A read or write is accepted every enabled clock, no turnaround.
// - Write strobe requests a write; lane selects pick written lanes.
// - Data drivers are off during the data phase of a write.
// - Selected only when all three chip selects are active.
// - Output enable gates the data drivers without the clock.
// - Bursts step in linear or interleaved order, chosen by input.
// - Low power when sleep requested or deselected by chip selects.
// - Read data appears in the same clock period as its command.
`default_nettype none
module ftsp_port import ftsp_pkg::*; (
   input wire logic mclk_i,                     // 200 MHz clock
   input wire logic resetn_i,                   // Async reset, active low
   input wire logic [ADDR_W-1:0] addr_i,        // Word address
   input wire logic advance_or_load_i,          // High continues burst
   input wire logic write_strobe_n_i,           // Low requests write
   input wire logic [LANES-1:0] byte_lane_write_sel_n_i, // Lane selects
   input wire logic chip_select_first_n_i,      // Active low select
   input wire logic chip_select_second_i,       // Active high select
   input wire logic chip_select_third_n_i,      // Active low select
   input wire logic clock_qualify_n_i,          // Low enables the edge
   input wire logic out_enable_n_i,             // Low lets drivers on
   input wire logic sleep_request_i,            // High enters sleep
   input wire logic burst_linear_i,             // High linear order
   input wire logic [DATA_W-1:0] dq_i,          // Data bus in
   output logic [DATA_W-1:0] dq_o,              // Data bus out
   output logic dq_oe_o,                        // High drives the bus
   output logic [DATA_W-1:0] rd_data_o,         // Buffered read word
   output logic rd_valid_o,                     // Buffered word valid
   input wire logic rd_ready_i,                 // Receiver takes word
   output logic buf_ready_o,                    // Low: port stalled
   output logic power_down_o                    // Low-power state
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);

   ftsp_rdbuf_if bif();

   ftsp_rdbuf u_buf (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .bus(bif.buf_mp)
   );

   logic [DATA_W-1:0] mem [0:MEM_DEPTH-1];

   ftsp_op_t op_q, op_d;
   logic [ADDR_W-1:0] acc_q, acc_d;
   logic [BURST_W-1:0] base_q, base_d, cnt_q, cnt_d;
   logic [LANES-1:0] bw_q, bw_d;
   logic drive_q, drive_d, pdown_q, pdown_d;
   logic [DATA_W-1:0] dq_q, dq_d, rd_word, wmask;
   logic en, sel, wr_now;

   // Low burst bits from base and beat count
   function automatic logic [BURST_W-1:0] burst_lo(
      input logic [BURST_W-1:0] base,
      input logic [BURST_W-1:0] cnt,
      input logic lin);
      burst_lo = lin ? base + cnt : base ^ cnt;
   endfunction

   // Lane-masked merge of new data over old
   function automatic logic [DATA_W-1:0] merge(
      input logic [DATA_W-1:0] old_w,
      input logic [DATA_W-1:0] new_w,
      input logic [DATA_W-1:0] m);
      merge = (old_w & ~m) | (new_w & m);
   endfunction

   // Each select covers data and parity bits of its lane
   for (genvar l = 0; l < LANES; l++) begin : g_lane
      assign wmask[l*LANE_W +: LANE_W] = {LANE_W{~bw_q[l]}};
   end

   // Stall when clock is unqualified or read buffer is full
   assign en = ~clock_qualify_n_i & bif.in_ready;
   assign sel = ~chip_select_first_n_i & chip_select_second_i
                & ~chip_select_third_n_i & ~sleep_request_i;
   assign wr_now = en & (op_q == OP_WRITE);

   // Next command, address, burst count and lane selects
   always_comb begin
      op_d = op_q;
      acc_d = acc_q;
      base_d = base_q;
      cnt_d = cnt_q;
      bw_d = bw_q;
      if (en) begin
         if (advance_or_load_i && !sleep_request_i) begin
            cnt_d = cnt_q + CNT_ONE;
            acc_d = {acc_q[ADDR_W-1:BURST_W],
                     burst_lo(base_q, cnt_d, burst_linear_i)};
            if (op_q == OP_WRITE) begin
               bw_d = byte_lane_write_sel_n_i;
            end
         end else if (!advance_or_load_i && sel) begin
            acc_d = addr_i;
            base_d = addr_i[BURST_W-1:0];
            cnt_d = CNT_ZERO;
            op_d = write_strobe_n_i ? OP_READ : OP_WRITE;
            bw_d = byte_lane_write_sel_n_i;
         end else begin
            op_d = OP_IDLE;
         end
      end
   end

   // Read word, forwarded from a write committing this same edge
   always_comb begin
      rd_word = mem[acc_d];
      if (wr_now && acc_d == acc_q) begin
         rd_word = merge(mem[acc_d], dq_i, wmask);
      end
      drive_d = drive_q;
      dq_d = dq_q;
      if (en) begin
         drive_d = (op_d == OP_READ);
         dq_d = (op_d == OP_READ) ? rd_word : dq_q;
      end
      // Sleep drops the drivers even on a frozen edge, like power down
      if (sleep_request_i) begin
         drive_d = 1'b0;
      end
      pdown_d = sleep_request_i | (en ? op_d == OP_IDLE : pdown_q);
   end

   // Port state registers; memory words are never reset
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         op_q <= OP_IDLE;
         acc_q <= '0;
         base_q <= CNT_ZERO;
         cnt_q <= CNT_ZERO;
         bw_q <= BW_RST;
         drive_q <= 1'b0;
         dq_q <= DQ_RST;
         pdown_q <= 1'b1;
      end else begin
         op_q <= op_d;
         acc_q <= acc_d;
         base_q <= base_d;
         cnt_q <= cnt_d;
         bw_q <= bw_d;
         drive_q <= drive_d;
         dq_q <= dq_d;
         pdown_q <= pdown_d;
      end
   end

   // Write data phase: self-timed commit one enabled edge after command
   always_ff @(posedge mclk_i) begin
      if (wr_now) begin
         mem[acc_q] <= merge(mem[acc_q], dq_i, wmask);
      end
   end

   // Read words also enter the buffer so a stalled receiver loses none
   assign bif.in_valid = en & (op_d == OP_READ);
   assign bif.in_data = rd_word;
   assign bif.out_ready = rd_ready_i;

   assign dq_o = dq_q;
   // Only gate past the flop: output enable acts without the clock
   assign dq_oe_o = drive_q & ~out_enable_n_i;
   assign rd_data_o = bif.out_data;
   assign rd_valid_o = bif.out_valid;
   assign buf_ready_o = bif.in_ready;
   assign power_down_o = pdown_q;

   // Protocol checks on what the port itself drives
   load_addr_a: assert property (
      en && !advance_or_load_i && sel |=> acc_q == $past(addr_i))
      else $error("load address not captured");
   freeze_a: assert property (
      !en && !sleep_request_i |=> $stable(acc_q) && $stable(op_q)
      && $stable(dq_q) && $stable(drive_q))
      else $error("state moved on an unqualified edge");
   back_to_back_a: assert property (
      en && op_q == OP_WRITE && !advance_or_load_i && sel
      && write_strobe_n_i |=> op_q == OP_READ && drive_q)
      else $error("read after write not accepted");
   write_hiz_a: assert property (
      op_q == OP_WRITE |-> !dq_oe_o)
      else $error("driver on during write data phase");
   select_gate_a: assert property (
      en && !advance_or_load_i && !sel |=> op_q == OP_IDLE && !drive_q)
      else $error("access without full chip select");
   oe_gate_a: assert property (
      out_enable_n_i |-> !dq_oe_o)
      else $error("drivers on while output enable inactive");
   linear_step_a: assert property (
      en && advance_or_load_i && !sleep_request_i && burst_linear_i
      |=> acc_q[BURST_W-1:0] == $past(acc_q[BURST_W-1:0]) + CNT_ONE
      && acc_q[ADDR_W-1:BURST_W] == $past(acc_q[ADDR_W-1:BURST_W]))
      else $error("linear burst step wrong");
   interleave_step_a: assert property (
      en && advance_or_load_i && !sleep_request_i && !burst_linear_i
      |=> acc_q[BURST_W-1:0] == ($past(base_q) ^ ($past(cnt_q) + CNT_ONE))
      && acc_q[ADDR_W-1:BURST_W] == $past(acc_q[ADDR_W-1:BURST_W]))
      else $error("interleaved burst step wrong");
   sleep_pd_a: assert property (
      sleep_request_i |=> power_down_o && !drive_q)
      else $error("sleep not entered");
   flow_read_a: assert property (
      en && op_d == OP_READ |=> drive_q && dq_o == $past(rd_word))
      else $error("read data not in same period");
   lane_write_a: assert property (
      wr_now |=> (mem[$past(acc_q)] & ~$past(wmask))
      == ($past(mem[acc_q]) & ~$past(wmask))
      && (mem[$past(acc_q)] & $past(wmask)) == ($past(dq_i) & $past(wmask)))
      else $error("byte lanes written wrongly");
   deselect_pd_a: assert property (
      en && !advance_or_load_i && !sel |=> power_down_o)
      else $error("deselect did not power down");
   write_load_a: assert property (
      en && !advance_or_load_i && sel && !write_strobe_n_i
      |=> op_q == OP_WRITE && bw_q == $past(byte_lane_write_sel_n_i))
      else $error("write command not taken");
   burst_write_a: assert property (
      en && advance_or_load_i && !sleep_request_i && op_q == OP_WRITE
      |=> op_q == OP_WRITE && bw_q == $past(byte_lane_write_sel_n_i))
      else $error("write burst not continued");
endmodule
`default_nettype wire

// File: sim/ftsp_host_model.sv
// Host-side model: shared data bus and read-word receiver
`default_nettype none
module ftsp_host_model import ftsp_pkg::*; (
   input wire logic mclk_i,                 // Clock
   input wire logic [DATA_W-1:0] dev_dq_i,  // Device drive value
   input wire logic dev_oe_i,               // Device drives bus
   input wire logic host_oe_i,              // Host drives write data
   input wire logic [DATA_W-1:0] host_dq_i, // Write data
   input wire logic stall_i,                // Receiver stalls
   output logic [DATA_W-1:0] bus_o,         // Resolved bus level
   output logic contend_o,                  // Both sides drive
   output logic rd_ready_o                  // Takes read words
);
   logic [DATA_W-1:0] last_q;
   // No pull on the bus: a released bus shows the inverse of its last level
   always_comb begin
      if (host_oe_i) begin
         bus_o = host_dq_i;
      end else if (dev_oe_i) begin
         bus_o = dev_dq_i;
      end else begin
         bus_o = ~last_q;
      end
   end
   assign contend_o = host_oe_i & dev_oe_i;
   assign rd_ready_o = ~stall_i;
   // Remember the last bus level
   always_ff @(posedge mclk_i) begin
      last_q <= bus_o;
   end
endmodule
`default_nettype wire

// File: sim/tb_flow_through_sync_sram_port.sv
// Self-checking bench for the flow-through SRAM port
`default_nettype none
module tb_flow_through_sync_sram_port import ftsp_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [ADDR_W-1:0] A = 19'h2a5b7;
   localparam logic [ADDR_W-1:0] B = 19'h5a5a4;
   localparam logic [DATA_W-1:0] D1 = 36'h1_2345_6789;
   localparam logic [DATA_W-1:0] D2 = 36'hf_edcb_a987;
   logic clk = 0, rn = 0, adv = 0, wn = 1, cs1n = 1, cs2 = 0, cs3n = 1;
   logic cqn = 0, oen = 0, slp = 0, lin = 1, hoe = 0, stall = 0, pw = 0;
   logic [ADDR_W-1:0] addr = '0;
   logic [LANES-1:0] bw = 4'hf;
   logic [DATA_W-1:0] wd = '0, dqi, dqo, rdd;
   logic [DATA_W-1:0] bd [4];
   logic dqoe, rdv, rdy, brdy, pd, cont;
   int bad_count = 0, num_checks = 0;
   // 200 MHz clock
   always #2.5 clk = ~clk;
   ftsp_port dut (.mclk_i(clk), .resetn_i(rn), .addr_i(addr),
      .advance_or_load_i(adv), .write_strobe_n_i(wn),
      .byte_lane_write_sel_n_i(bw), .chip_select_first_n_i(cs1n),
      .chip_select_second_i(cs2), .chip_select_third_n_i(cs3n),
      .clock_qualify_n_i(cqn), .out_enable_n_i(oen), .sleep_request_i(slp),
      .burst_linear_i(lin), .dq_i(dqi), .dq_o(dqo), .dq_oe_o(dqoe),
      .rd_data_o(rdd), .rd_valid_o(rdv), .rd_ready_i(rdy),
      .buf_ready_o(brdy), .power_down_o(pd));
   ftsp_host_model host (.mclk_i(clk), .dev_dq_i(dqo), .dev_oe_i(dqoe),
      .host_oe_i(hoe), .host_dq_i(wd), .stall_i(stall), .bus_o(dqi),
      .contend_o(cont), .rd_ready_o(rdy));
   task automatic ck(input string n, input logic [DATA_W-1:0] e, s);
      num_checks++;
      if (e !== s) begin
         $display("ERROR %s expected %h seen %h", n, e, s);
         bad_count++;
      end
   endtask
   // One command per call; the previous write's data rides along with it
   task automatic go(input logic a_adv, a_wn, input logic [ADDR_W-1:0] a,
      input logic [LANES-1:0] b, input logic [DATA_W-1:0] d, input logic s);
      @(posedge clk);
      adv <= a_adv;
      wn <= a_wn;
      addr <= a;
      bw <= b;
      cs1n <= 1'b0;
      cs2 <= s;
      cs3n <= 1'b0;
      slp <= 1'b0;
      wd <= d;
      hoe <= pw;
      pw = s & ~a_wn;
   endtask
   // Waits a bounded time for a read word, compares it at the negedge
   task automatic take(input logic [DATA_W-1:0] e);
      int n;
      n = 0;
      @(negedge clk);
      while (rdv !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      ck("rd_valid", 1'b1, rdv);
      ck("rd_data", e, rdd);
   endtask
   task automatic t_rw();
      go(1'b0, 1'b0, A, 4'h0, '0, 1'b1);
      go(1'b0, 1'b0, A, 4'he, D1, 1'b1);
      go(1'b0, 1'b1, A, 4'hf, D2, 1'b1);
      #1 ck("oe_wr", 1'b0, dqoe);
      fork
         take({D1[35:9], D2[8:0]});
         begin
            go(1'b0, 1'b1, '0, 4'hf, '0, 1'b0);
            #1 ck("dq_o", {D1[35:9], D2[8:0]}, dqo);
            ck("oe_rd", 1'b1, dqoe);
         end
      join
      $display("done rw");
   endtask
   task automatic t_burst();
      int ord [8] = '{0, 3, 2, 1, 2, 3, 0, 1};
      for (int k = 0; k < 4; k++) bd[k] = 36'h0_0f0f_0f0f << k;
      @(posedge clk);
      lin <= 1'b1;
      go(1'b0, 1'b0, B | 19'h1, 4'h0, '0, 1'b1);
      for (int k = 0; k < 3; k++) go(1'b1, 1'b0, '0, 4'h0, bd[k], 1'b1);
      go(1'b0, 1'b1, '0, 4'hf, bd[3], 1'b0);
      lin <= 1'b0;
      fork
         begin
            go(1'b0, 1'b1, B | 19'h1, 4'hf, '0, 1'b1);
            repeat (3) go(1'b1, 1'b1, '0, 4'hf, '0, 1'b1);
            go(1'b0, 1'b1, '0, 4'hf, '0, 1'b0);
            lin <= 1'b1;
            go(1'b0, 1'b1, B | 19'h3, 4'hf, '0, 1'b1);
            repeat (3) go(1'b1, 1'b1, '0, 4'hf, '0, 1'b1);
            go(1'b0, 1'b1, '0, 4'hf, '0, 1'b0);
         end
         foreach (ord[i]) take(bd[ord[i]]);
      join
      $display("done burst");
   endtask
   // Drop each select in turn, then sleep in mid-burst
   task automatic t_sel();
      for (int i = 0; i < 4; i++) begin
         go(1'b0, 1'b1, B, 4'hf, '0, 1'b1);
         @(posedge clk);
         adv <= (i == 3);
         cs1n <= (i == 0);
         cs2 <= (i != 1);
         cs3n <= (i == 2);
         slp <= (i == 3);
         #1 ck("pd_sel", 1'b0, pd);
         @(posedge clk);
         #1 ck("pd_off", 1'b1, pd);
         ck("oe_off", 1'b0, dqoe);
      end
      $display("done sel");
   endtask
   task automatic t_hold();
      go(1'b0, 1'b1, B, 4'hf, '0, 1'b1);
      @(posedge clk);
      cqn <= 1'b1;
      addr <= B | 19'h2;
      #1 ck("dq_rd", bd[3], dqo);
      repeat (3) @(posedge clk);
      oen <= 1'b1;
      #1 ck("dq_held", bd[3], dqo);
      ck("oe_gate", 1'b0, dqoe);
      @(posedge clk);
      oen <= 1'b0;
      #1 ck("oe_back", 1'b1, dqoe);
      @(posedge clk);
      cqn <= 1'b0;
      go(1'b0, 1'b1, '0, 4'hf, '0, 1'b0);
      #1 ck("dq_next", bd[1], dqo);
      $display("done hold");
   endtask
   // Fill the read buffer with the receiver stalled, then drain it
   task automatic t_buf();
      int n;
      repeat (4) @(posedge clk);
      stall <= 1'b1;
      go(1'b0, 1'b1, B | 19'h1, 4'hf, '0, 1'b1);
      go(1'b0, 1'b1, B | 19'h2, 4'hf, '0, 1'b1);
      go(1'b0, 1'b1, B | 19'h3, 4'hf, '0, 1'b1);
      n = 0;
      while (brdy !== 1'b0 && n < 8) begin
         @(negedge clk);
         n++;
      end
      ck("buf_full", 1'b0, brdy);
      repeat (3) @(posedge clk);
      stall <= 1'b0;
      #1 ck("rd_held", bd[0], rdd);
      fork
         for (int k = 0; k < 3; k++) take(bd[k]);
         begin
            n = 0;
            do begin
               @(negedge clk);
               n++;
            end while (brdy !== 1'b1 && n < 8);
            go(1'b0, 1'b1, '0, 4'hf, '0, 1'b0);
         end
      join
      $display("done buf");
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Both sides on the bus at once is never allowed
   always @(posedge clk) begin
      if (cont === 1'b1) ck("contention", 1'b0, cont);
   end
   initial begin
      repeat (20) @(posedge clk);
      ck("pd_rst", 1'b1, pd);
      rn <= 1'b1;
      t_rw();
      t_burst();
      t_sel();
      t_hold();
      t_buf();
      finish_test();
   end
   // Tests need about a hundred cycles; cut a hang well beyond that
   initial begin
      #20000;
      bad_count++;
      finish_test();
   end
endmodule
`default_nettype wire
